// ===== core/ledst_pkg.sv
// constants and register layout for the led status output block
//
// Summary of operation
// - status bit 15 is the unstretched OR of every enabled event term.
// - status bit 15 is read only, writes ignored, no reset acts on it.
// - polarity one drives the pin high while status true, low while false.
// - polarity zero pulls the pin low while true, releases it while false.
// - polarity affects only the pin, never the readable status bit.
// - disable bit 13 set keeps the pin released whatever the status.
// - fast speed enable bit 12 adds a term while the link runs 100 Mbps.
// - hardware reset sets fast speed and stretch enables, clears the others.
// - soft reset and stop leave all writable configuration bits unchanged.
// - enable bit 9 adds a term on wake frame with wake detection on.
// - enable bit 8 adds a term only in link pass with full duplex on.
// - stretch enable bit 7 lengthens on-time per new event; zero disables it.
// - enable bit 6 adds a term while the link is in pass state.
// - enable bit 5 adds a term for receive activity passing address match.
// - enable bit 4 adds a term on transmit activity.
// - enable bit 2 adds a term on any receive activity.
// - enable bit 0 adds a term on collision activity.
// - led register writes take effect only while release bit 12 is one.
// - the low sixteen bits may be loaded by the eeprom preload.
// - bits 31-16 undefined on read, bits 11-10 and 3 written and read zero.
package ledst_pkg;

    // ========================================================================
    // register map
    localparam logic [11:0] LEDST_LED_CFG_OFF  = 12'h000;
    localparam logic [11:0] LEDST_MISC_CFG_OFF = 12'h004;
    localparam logic [11:0] LEDST_EVENT_OFF    = 12'h008;

    // ========================================================================
    // led configuration fields
    localparam int LEDST_FUNC_OR_BIT   = 15;
    localparam int LEDST_POLARITY_BIT  = 14;
    localparam int LEDST_DISABLE_BIT   = 13;
    localparam int LEDST_STRETCH_BIT   = 7;
    localparam int LEDST_RELEASE_BIT   = 12;
    localparam int LEDST_NUM_EVENTS    = 8;

    // enable bit position of each event source, index order of the event bus
    localparam int LEDST_EVT_POS [LEDST_NUM_EVENTS] = '{0, 2, 4, 5, 6, 8, 9, 12};

    localparam logic [15:0] LEDST_WRITE_MASK = 16'h73f5;
    localparam logic [15:0] LEDST_CFG_RESET  = 16'h1080;

    // ========================================================================
    // stretch timing
    localparam int LEDST_CLK_PERIOD_NS = 10;
    localparam int LEDST_STRETCH_US    = 100;
    localparam int LEDST_STRETCH_CYCLES = (LEDST_STRETCH_US * 1000) / LEDST_CLK_PERIOD_NS;

endpackage // ledst_pkg

// ===== core/ledst_led_status.sv
// led status output pin with apb register access, preload and pulse stretch
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps

module ledst_led_status
    import ledst_pkg::*;
#(
    parameter int STRETCH_CYCLES = LEDST_STRETCH_CYCLES,
    parameter int CNT_W          = 24
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // ========================================================================
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // ========================================================================
    // eeprom preload
    input  wire logic        eeprom_preload,
    input  wire logic [15:0] eeprom_preload_data,
    // ========================================================================
    // mac event sources
    input  wire logic        link_pass,
    input  wire logic        full_duplex_on,
    input  wire logic        speed_100,
    input  wire logic        tx_activity,
    input  wire logic        rx_activity,
    input  wire logic        rx_match,
    input  wire logic        collision,
    input  wire logic        wake_mode_on,
    input  wire logic        wake_frame_rx,
    // ========================================================================
    // led pin
    output logic             led_pin_o,
    output logic             led_pin_oe
);

    // ========================================================================
    // state
    logic [15:0]                 cfg_q;
    logic [15:0]                 cfg_d;
    logic                        release_q;
    logic                        release_d;
    logic [LEDST_NUM_EVENTS-1:0] term_prev_q;
    logic [CNT_W-1:0]            stretch_q;
    logic [CNT_W-1:0]            stretch_d;
    logic [31:0]                 prdata_q;
    logic [31:0]                 prdata_d;
    logic                        pready_q;
    logic                        pready_d;
    logic                        pslverr_q;
    logic                        pslverr_d;
    logic                        led_o_q;
    logic                        led_o_d;
    logic                        led_oe_q;
    logic                        led_oe_d;

    // ========================================================================
    // configuration fields
    logic [LEDST_NUM_EVENTS-1:0] evt_enable;
    logic                        collision_enable;
    logic                        rx_activity_enable;
    logic                        tx_activity_enable;
    logic                        rx_match_enable;
    logic                        link_pass_enable;
    logic                        full_duplex_link_enable;
    logic                        wake_frame_enable;
    logic                        fast_speed_enable;
    logic                        pulse_stretch_enable;
    logic                        pin_disable;
    logic                        pin_polarity_select;

    assign collision_enable        = cfg_q[LEDST_EVT_POS[0]];
    assign rx_activity_enable      = cfg_q[LEDST_EVT_POS[1]];
    assign tx_activity_enable      = cfg_q[LEDST_EVT_POS[2]];
    assign rx_match_enable         = cfg_q[LEDST_EVT_POS[3]];
    assign link_pass_enable        = cfg_q[LEDST_EVT_POS[4]];
    assign full_duplex_link_enable = cfg_q[LEDST_EVT_POS[5]];
    assign wake_frame_enable       = cfg_q[LEDST_EVT_POS[6]];
    assign fast_speed_enable       = cfg_q[LEDST_EVT_POS[7]];
    assign pulse_stretch_enable    = cfg_q[LEDST_STRETCH_BIT];
    assign pin_disable             = cfg_q[LEDST_DISABLE_BIT];
    assign pin_polarity_select     = cfg_q[LEDST_POLARITY_BIT];

    // packed in event bus order
    assign evt_enable = {fast_speed_enable, wake_frame_enable, full_duplex_link_enable,
                         link_pass_enable, rx_match_enable, tx_activity_enable,
                         rx_activity_enable, collision_enable};

    // ========================================================================
    // event terms
    logic [LEDST_NUM_EVENTS-1:0] evt_src;
    logic [LEDST_NUM_EVENTS-1:0] evt_term;
    logic [LEDST_NUM_EVENTS-1:0] evt_rise;
    logic                        led_function_or;
    logic                        new_event;

    // bus order matches LEDST_EVT_POS
    assign evt_src[0] = collision;
    assign evt_src[1] = rx_activity;
    assign evt_src[2] = tx_activity;
    assign evt_src[3] = rx_match;
    assign evt_src[4] = link_pass;
    assign evt_src[5] = link_pass & full_duplex_on;
    assign evt_src[6] = wake_mode_on & wake_frame_rx;
    assign evt_src[7] = speed_100;

    genvar gi;
    generate
        for (gi = 0; gi < LEDST_NUM_EVENTS; gi++) begin : g_evt
            assign evt_term[gi] = evt_src[gi] & evt_enable[gi];
            assign evt_rise[gi] = evt_term[gi] & ~term_prev_q[gi];
        end
    endgenerate

    assign led_function_or = |evt_term;
    assign new_event       = |evt_rise;

    // ========================================================================
    // pulse stretcher
    // a level event such as link pass keeps the pin lit through the OR term
    // alone; the stretcher only matters for short activity bursts
    logic stretch_on;
    logic stretch_busy;
    logic led_lit;

    localparam logic [CNT_W-1:0] STRETCH_LOAD = CNT_W'(STRETCH_CYCLES);

    assign stretch_on   = pulse_stretch_enable;
    assign stretch_busy = (stretch_q != '0);

    always_comb begin
        stretch_d = stretch_q;
        if (!stretch_on) begin
            stretch_d = '0;
        end else if (new_event) begin
            stretch_d = STRETCH_LOAD;
        end else if (stretch_busy) begin
            stretch_d = stretch_q - CNT_W'(1);
        end
    end

    assign led_lit = led_function_or | (stretch_on & stretch_busy);

    // ========================================================================
    // pin drive
    // disabled means released in both modes, so an open drain board pull-up
    // and a totem pole board both see the led dark
    always_comb begin
        led_o_d  = 1'b0;
        led_oe_d = 1'b0;
        if (pin_disable) begin
            led_o_d  = 1'b0;
            led_oe_d = 1'b0;
        end else if (pin_polarity_select) begin
            led_o_d  = led_lit;
            led_oe_d = 1'b1;
        end else begin
            led_o_d  = 1'b0;
            led_oe_d = led_lit;
        end
    end

    // ========================================================================
    // apb decode
    logic setup_ph;
    logic access_ph;
    logic hit_cfg;
    logic hit_misc;
    logic hit_evt;
    logic hit_any;
    logic wr_cfg;
    logic wr_misc;
    logic lo_lanes;
    logic hi_lane;

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable & pready_q;
    // zero wait states: the answer always follows its setup cycle
    assign pready_d  = setup_ph;
    assign hit_cfg   = (paddr == LEDST_LED_CFG_OFF);
    assign hit_misc  = (paddr == LEDST_MISC_CFG_OFF);
    assign hit_evt   = (paddr == LEDST_EVENT_OFF);
    assign hit_any   = hit_cfg | hit_misc | hit_evt;
    // a narrow write only touches the lanes it names
    assign lo_lanes  = pstrb[0];
    assign hi_lane   = pstrb[1];
    assign wr_cfg    = access_ph & pwrite & hit_cfg & release_q;
    assign wr_misc   = access_ph & pwrite & hit_misc;

    // ========================================================================
    // configuration next value
    logic [15:0] cfg_wmask;

    assign cfg_wmask = LEDST_WRITE_MASK & {{8{hi_lane}}, {8{lo_lanes}}};

    always_comb begin
        cfg_d = cfg_q;
        if (eeprom_preload) begin
            // preload wins over a bus write in the same cycle
            cfg_d = eeprom_preload_data & LEDST_WRITE_MASK;
        end else if (wr_cfg) begin
            cfg_d = (cfg_q & ~cfg_wmask) | (pwdata[15:0] & cfg_wmask);
        end
    end

    always_comb begin
        release_d = release_q;
        if (wr_misc && hi_lane) begin
            release_d = pwdata[LEDST_RELEASE_BIT];
        end
    end

    // ========================================================================
    // read data, taken in the setup cycle
    logic [31:0] rd_cfg;
    logic [31:0] rd_misc;
    logic [31:0] rd_evt;

    always_comb begin
        rd_cfg                    = {16'h0000, cfg_q};
        rd_cfg[LEDST_FUNC_OR_BIT] = led_function_or;
    end

    always_comb begin
        rd_misc                    = 32'h0000_0000;
        rd_misc[LEDST_RELEASE_BIT] = release_q;
    end

    assign rd_evt = {22'h00_0000, stretch_busy, led_lit, evt_src};

    always_comb begin
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (setup_ph) begin
            prdata_d  = 32'h0000_0000;
            pslverr_d = ~hit_any;
            if (!pwrite) begin
                if (hit_cfg) begin
                    prdata_d = rd_cfg;
                end else if (hit_misc) begin
                    prdata_d = rd_misc;
                end else if (hit_evt) begin
                    prdata_d = rd_evt;
                end
            end
        end
    end

    // ========================================================================
    // registers
    // only the hardware reset touches the configuration; there is no soft
    // reset or stop path into this block at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= LEDST_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // release bit resets low so a stray write after power-up is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            release_q <= 1'b0;
        end else begin
            release_q <= release_d;
        end
    end

    // enabling a source whose event is already on counts as a new occurrence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_prev_q <= '0;
        end else begin
            term_prev_q <= evt_term;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stretch_q <= '0;
        end else begin
            stretch_q <= stretch_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= pslverr_d;
        end
    end

    // pin flops sit last so the pad never sees a decode glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_o_q <= 1'b0;
        end else begin
            led_o_q <= led_o_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_oe_q <= 1'b0;
        end else begin
            led_oe_q <= led_oe_d;
        end
    end

    // ========================================================================
    // outputs
    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign led_pin_o  = led_o_q;
    assign led_pin_oe = led_oe_q;

endmodule // ledst_led_status

// ===== sim/ledst_led_status_props.sv
// assertion checker for the led status output block
`timescale 1ns/1ps
module ledst_led_status_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        led_pin_o,
    input wire logic        led_pin_oe
);
    wire setup = psel && !penable;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================
    // register bus
    cfg_write_ok_a: assert property (setup && pwrite && paddr == 12'h000 |=> pready && !pslverr)
        else $error("config write answered with error");
    unmapped_err_a: assert property (setup && paddr > 12'h008 |=> pready && pslverr)
        else $error("unmapped access not refused");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    hi_read_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    rsvd_read_zero_a: assert property (pready && !pwrite && paddr == 12'h000
        |-> prdata[11:10] == 2'h0 && !prdata[3])
        else $error("reserved config bits not zero");
    read_hold_a: assert property (pready ##1 !setup |-> $stable(prdata))
        else $error("read data moved without a request");
    // ========================================
    // pin
    pin_drive_a: assert property (led_pin_o |-> led_pin_oe)
        else $error("pin high while not driven");
    reset_dark_a: assert property ($rose(presetn) |-> !led_pin_oe && !led_pin_o)
        else $error("pin driven at reset release");
    cover property (setup && pwrite ##1 pready);
    cover property (pready && pslverr);
    cover property (led_pin_oe && led_pin_o ##1 led_pin_oe && !led_pin_o);
endmodule // ledst_led_status_props

bind ledst_led_status ledst_led_status_props ledst_led_status_props_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .led_pin_o(led_pin_o),
    .led_pin_oe(led_pin_oe));

// ===== sim/ledst_led_board.sv
// board model of the status led pad with its pull-up
`timescale 1ns/1ps
module ledst_led_board (
    input  wire logic led_pin_o,
    input  wire logic led_pin_oe,
    output logic      pad
);
    // released pad floats high through the board pull-up
    assign pad = led_pin_oe ? led_pin_o : 1'b1;
endmodule // ledst_led_board

// ===== sim/ledst_led_status_bench.sv
// self-checking testbench for the led status output block
`timescale 1ns/1ps
module ledst_led_status_bench;
    import ledst_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        led_pin_o, led_pin_oe, pad, eeprom_preload;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] eeprom_preload_data;
    logic [8:0]  ev;
    int          fails, checked;
    // event order: col rx tx match link fd speed wake_mode wake_frame
    int          pos [8] = '{0, 2, 4, 5, 6, 8, 9, 12};
    logic [8:0]  drv [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h030, 9'h180, 9'h040};
    logic [8:0]  half [8] = '{9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h020, 9'h100, 9'h0};

    ledst_led_status #(.STRETCH_CYCLES(8)) ledst_led_status_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eeprom_preload(eeprom_preload), .eeprom_preload_data(eeprom_preload_data),
        .link_pass(ev[4]), .full_duplex_on(ev[5]), .speed_100(ev[6]), .tx_activity(ev[2]),
        .rx_activity(ev[1]), .rx_match(ev[3]), .collision(ev[0]), .wake_mode_on(ev[7]),
        .wake_frame_rx(ev[8]), .led_pin_o(led_pin_o), .led_pin_oe(led_pin_oe));
    ledst_led_board ledst_led_board_i (.led_pin_o(led_pin_o), .led_pin_oe(led_pin_oe), .pad(pad));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ========================================
    // shared tasks
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic seen;
        seen = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer read settled just before the rising edge that samples it
        while (seen !== 1'b1) begin
            @(negedge pclk);
            seen = pready;
            rd = prdata;
            er = pslverr;
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // {drive enable, pad level}
    task pin(input logic [1:0] exp);
        cyc(3);
        @(negedge pclk);
        chk({30'h0, led_pin_oe, pad}, {30'h0, exp});
    endtask
    task drive(input logic [8:0] v);
        @(posedge pclk);
        ev <= v;
    endtask
    task hw_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        cyc(10);
        presetn <= 1'b1;
    endtask
    // ========================================
    // scenarios
    task s_reset;
        rdchk(12'h000, 32'h1080);
        rdchk(12'h004, 32'h0);
        pin(2'b01);
    endtask
    task s_protect;
        apb(1'b1, 12'h000, 32'h4011);
        rdchk(12'h000, 32'h1080);
        apb(1'b1, 12'h004, 32'h1000);
        apb(1'b1, 12'h000, 32'hffffffff);
        rdchk(12'h000, 32'h73f5);
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask
    task s_events;
        logic [15:0] en;
        for (int i = 0; i < 8; i++) begin
            en = 16'h1 << pos[i];
            apb(1'b1, 12'h000, {16'h0, 16'h4000 | en});
            drive(half[i]);
            pin(2'b10);
            drive(drv[i]);
            pin(2'b11);
            rdchk(12'h000, {16'h0, 16'hc000 | en});
            apb(1'b1, 12'h000, 32'h4000);
            pin(2'b10);
            drive(9'h0);
        end
    endtask
    task s_polar;
        apb(1'b1, 12'h000, 32'h0001);
        drive(9'h001);
        pin(2'b10);
        rdchk(12'h000, 32'h8001);
        apb(1'b1, 12'h000, 32'h6001);
        pin(2'b01);
        drive(9'h0);
    endtask
    task s_stretch;
        apb(1'b1, 12'h000, 32'h4081);
        drive(9'h001);
        drive(9'h0);
        pin(2'b11);
        drive(9'h001);
        drive(9'h0);
        // past the end of the first stretch, inside the restarted one
        cyc(3);
        pin(2'b11);
        cyc(9);
        pin(2'b10);
    endtask
    task s_preload;
        apb(1'b1, 12'h004, 32'h0);
        @(posedge pclk);
        eeprom_preload <= 1'b1;
        eeprom_preload_data <= 16'hffff;
        @(posedge pclk);
        eeprom_preload <= 1'b0;
        rdchk(12'h000, 32'h73f5);
    endtask
    task conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        eeprom_preload = 1'b0;
        eeprom_preload_data = 16'h0;
        ev = 9'h0;
        hw_reset();
        s_reset();
        s_protect();
        s_events();
        s_polar();
        s_stretch();
        s_preload();
        // second hardware reset in mid-run restores defaults
        hw_reset();
        s_reset();
        conclude();
    end
    initial begin
        #300us;
        fails++;
        conclude();
    end
endmodule // ledst_led_status_bench
